//--- rtl/uefc_map.svh
// uefc_map.svh: register indices, field positions and reset values
// assumes word-aligned wishbone access, byte address = index * 4
`ifndef UEFC_MAP_SVH
`define UEFC_MAP_SVH
// register word indices
`define UEFC_IDX_SCR 4'h0
`define UEFC_IDX_EFC 4'h1
`define UEFC_IDX_FRDY 4'h2
`define UEFC_IDX_IEN 4'h3
`define UEFC_IDX_IST 4'h4
`define UEFC_IDX_FCT 4'h5
`define UEFC_IDX_MDC 4'h6
`define UEFC_IDX_LNC 4'h7
`define UEFC_IDX_LNS 4'h8
`define UEFC_IDX_MDS 4'h9
`define UEFC_IDX_RES1 4'ha
`define UEFC_IDX_RES2 4'hb
`define UEFC_IDX_PAU1 4'hc
`define UEFC_IDX_PAU2 4'hd
// enhanced feature control fields
`define UEFC_EFC_ENH 4
`define UEFC_EFC_SPC 5
`define UEFC_EFC_ARTS 6
`define UEFC_EFC_ACTS 7
// modem control fields
`define UEFC_MDC_DTR 0
`define UEFC_MDC_RTS 1
`define UEFC_MDC_ANY 5
// reset values
`define UEFC_REG_RST 8'h00
`define UEFC_IST_RST 8'h01
`define UEFC_LNS_RST 8'h60
`define UEFC_PIN_RST 4'hf
`endif

//--- rtl/uefc_pkg.sv
// uefc_pkg: types shared by the enhanced flow control block
// assumes nothing beyond a systemverilog compiler
package uefc_pkg;
  // a character with its strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } uefc_char_s;
  // character selection of a two-bit flow field
  typedef enum logic [1:0] {
    UEFC_SEL_NONE = 2'b00,
    UEFC_SEL_SECOND = 2'b01,
    UEFC_SEL_FIRST = 2'b10,
    UEFC_SEL_BOTH = 2'b11
  } uefc_sel_e;
  // flow character sender states
  typedef enum logic [2:0] {
    UEFC_FC_IDLE = 3'b001,
    UEFC_FC_FIRST = 3'b010,
    UEFC_FC_SECOND = 3'b100
  } uefc_fc_e;
endpackage

//--- rtl/uefc_sync.sv
// uefc_sync: two flip-flop synchroniser for pin levels
// assumes inputs are asynchronous levels, reset is synchronous
module uefc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input logic clk_i,
  input logic rst_b_i,
  input logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r; // first stage, read only by the second
  logic [W-1:0] q_r; // second stage

  // two stages, reset to the idle pin level
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_r <= RST;
      q_r <= RST;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule

//--- rtl/uefc_seq_match.sv
// uefc_seq_match: matches one or two programmed characters
// assumes character strobes are single-cycle pulses on clk_i
module uefc_seq_match (
  input logic clk_i,
  input logic rst_b_i,
  input uefc_pkg::uefc_char_s ch_i,
  input uefc_pkg::uefc_sel_e sel_i,
  input logic [7:0] c1_i,
  input logic [7:0] c2_i,
  output logic hit_o
);
  logic seen_r; // last character equalled the first one

  // track the first half of a pair
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      seen_r <= 1'b0;
    end else if (ch_i.valid) begin
      seen_r <= (ch_i.data == c1_i);
    end
  end

  // single match or back to back pair
  always_comb begin
    hit_o = 1'b0;
    if (ch_i.valid) begin
      unique case (sel_i)
        uefc_pkg::UEFC_SEL_NONE: hit_o = 1'b0;
        uefc_pkg::UEFC_SEL_FIRST: hit_o = (ch_i.data == c1_i);
        uefc_pkg::UEFC_SEL_SECOND: hit_o = (ch_i.data == c2_i);
        uefc_pkg::UEFC_SEL_BOTH: hit_o = seen_r && (ch_i.data == c2_i);
      endcase
    end
  end
endmodule

//--- rtl/uefc_flow_ctl.sv
// uefc_flow_ctl: enhanced feature and flow control block, one channel
// assumes a classic wishbone master on clk_i and base uart logic beside
//
// The implementer's own choices: register access over Wishbone and the address map.
`include "uefc_map.svh"
module uefc_flow_ctl #(
  parameter int DEPTH = 64,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input logic clk_i,
  input logic rst_b_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [5:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input uefc_pkg::uefc_char_s rx_char_i,
  input logic [CW-1:0] rx_count_i,
  input logic [CW-1:0] rx_trig_i,
  input logic [3:0] tx_full_i,
  input logic [3:0] rx_above_i,
  input logic [3:0] rx_tout_i,
  input logic [7:0] line_status_i,
  input logic [3:0] modem_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic tx_hold_o,
  output logic rx_trig_evt_o,
  output uefc_pkg::uefc_char_s fc_char_o,
  input logic fc_ack_i,
  output logic [7:0] ien_o,
  output logic [7:0] fct_o,
  output logic [7:0] mdc_o,
  output logic [7:0] lnc_o
);
  logic ack_r; // bus answer
  logic [31:0] dat_r; // read data held during ack
  logic req, wr_en, rd_done; // bus decode
  logic [3:0] idx; // word index
  logic [7:0] rd_nxt; // read mux
  logic [7:0] scr_r, efc_r, ien_r, fct_r, mdc_r, lnc_r, lns_r;
  logic [7:0] res1_r, res2_r, pau1_r, pau2_r; // flow characters
  logic [7:0] ien_eff, fct_eff, mdc_eff, frdy; // visible values
  logic enh; // enhanced bits unlocked
  logic ist_spc_r, spc_hit; // special character flag
  logic [3:0] pin_s, pin_prev_r, dlt_r, dlt_set; // modem pins
  logic [1:0] settle_r; // cycles since reset, deltas held off until 3
  logic cts_n_s; // synced clear-to-send pin
  logic cnt_hi, cnt_lo, at_trig; // receive fill compares
  logic art_hi_r, art_hi_nxt, at_trig_r, evt_r, rts_n_r;
  logic paused_r, pause_hit, res_hit; // received flow state
  logic rem_paused_r, kind_r, kind_nxt; // sent flow state
  uefc_pkg::uefc_sel_e tx_sel, rx_sel;
  uefc_pkg::uefc_fc_e st_r, st_nxt;
  uefc_pkg::uefc_char_s fc_r, fc_nxt;

  // bus decode: writes and read side effects act on the ack edge
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[5:2];
  assign wr_en = req & wb_we_i & ack_r & wb_sel_i[0];
  assign rd_done = req & ~wb_we_i & ack_r;
  assign enh = efc_r[`UEFC_EFC_ENH];

  // one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read data captured as the request is first seen
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dat_r <= 32'h0;
    end else if (req & ~ack_r) begin
      dat_r <= {24'h0, rd_nxt};
    end
  end

  // enhanced bits read as default while locked
  assign ien_eff = {ien_r[7:4] & {4{enh}}, ien_r[3:0]};
  assign fct_eff = {fct_r[7:6], fct_r[5:4] & {2{enh}}, fct_r[3:0]};
  assign mdc_eff = {mdc_r[7:5] & {3{enh}}, mdc_r[4:0]};
  // transmit space low, receive below trigger high
  assign frdy = {~(rx_above_i | rx_tout_i), ~tx_full_i};

  // read mux, unmapped words read zero
  always_comb begin
    case (idx)
      `UEFC_IDX_SCR: rd_nxt = scr_r;
      `UEFC_IDX_EFC: rd_nxt = efc_r;
      `UEFC_IDX_FRDY: rd_nxt = frdy;
      `UEFC_IDX_IEN: rd_nxt = ien_eff;
      `UEFC_IDX_IST: rd_nxt = `UEFC_IST_RST | {3'h0, ist_spc_r & enh, 4'h0};
      `UEFC_IDX_FCT: rd_nxt = fct_eff;
      `UEFC_IDX_MDC: rd_nxt = mdc_eff;
      `UEFC_IDX_LNC: rd_nxt = lnc_r;
      `UEFC_IDX_LNS: rd_nxt = lns_r;
      `UEFC_IDX_MDS: rd_nxt = {~pin_s, dlt_r};
      `UEFC_IDX_RES1: rd_nxt = res1_r;
      `UEFC_IDX_RES2: rd_nxt = res2_r;
      `UEFC_IDX_PAU1: rd_nxt = pau1_r;
      `UEFC_IDX_PAU2: rd_nxt = pau2_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // scratch byte
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scr_r <= `UEFC_REG_RST;
    end else if (wr_en && idx == `UEFC_IDX_SCR) begin
      scr_r <= wb_dat_i[7:0];
    end
  end

  // enhanced feature control, all bits clear at reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      efc_r <= `UEFC_REG_RST;
    end else if (wr_en && idx == `UEFC_IDX_EFC) begin
      efc_r <= wb_dat_i[7:0];
    end
  end

  // enhanced bits keep their stored value while locked
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ien_r <= `UEFC_REG_RST;
      fct_r <= `UEFC_REG_RST;
      mdc_r <= `UEFC_REG_RST;
      lnc_r <= `UEFC_REG_RST;
    end else if (wr_en) begin
      case (idx)
        `UEFC_IDX_IEN: begin
          ien_r <= {enh ? wb_dat_i[7:4] : ien_r[7:4], wb_dat_i[3:0]};
        end
        `UEFC_IDX_FCT: begin
          fct_r <= {wb_dat_i[7:6], enh ? wb_dat_i[5:4] : fct_r[5:4],
                    wb_dat_i[3:0]};
        end
        `UEFC_IDX_MDC: begin
          mdc_r <= {enh ? wb_dat_i[7:5] : mdc_r[7:5], wb_dat_i[4:0]};
        end
        `UEFC_IDX_LNC: lnc_r <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // resume and pause characters
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      res1_r <= `UEFC_REG_RST;
      res2_r <= `UEFC_REG_RST;
      pau1_r <= `UEFC_REG_RST;
      pau2_r <= `UEFC_REG_RST;
    end else if (wr_en) begin
      case (idx)
        `UEFC_IDX_RES1: res1_r <= wb_dat_i[7:0];
        `UEFC_IDX_RES2: res2_r <= wb_dat_i[7:0];
        `UEFC_IDX_PAU1: pau1_r <= wb_dat_i[7:0];
        `UEFC_IDX_PAU2: pau2_r <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // special character flag, set wins over read clear
  assign spc_hit = efc_r[`UEFC_EFC_SPC] & rx_char_i.valid &
                   (rx_char_i.data == pau2_r);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ist_spc_r <= 1'b0;
    end else if (spc_hit) begin
      ist_spc_r <= 1'b1;
    end else if (rd_done && idx == `UEFC_IDX_IST) begin
      ist_spc_r <= 1'b0;
    end
  end

  // line status follows the base logic after reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lns_r <= `UEFC_LNS_RST;
    end else begin
      lns_r <= line_status_i;
    end
  end

  // modem pins: [0] cts, [1] dsr, [2] ri, [3] cd, all active low
  uefc_sync #(.W(4), .RST(`UEFC_PIN_RST)) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(modem_n_i),
    .q_o(pin_s)
  );
  assign cts_n_s = pin_s[0];
  // ring delta only on the pin's low to high edge; masked while the
  // synchroniser refills after reset, which is no real pin change
  assign dlt_set = {pin_s[3] ^ pin_prev_r[3], pin_s[2] & ~pin_prev_r[2],
                    pin_s[1:0] ^ pin_prev_r[1:0]} & {4{&settle_r}};

  // modem deltas, set wins over the read clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_prev_r <= `UEFC_PIN_RST;
      settle_r <= 2'h0;
      dlt_r <= 4'h0;
    end else begin
      pin_prev_r <= pin_s;
      settle_r <= settle_r + {1'b0, ~&settle_r};
      if (rd_done && idx == `UEFC_IDX_MDS) begin
        dlt_r <= dlt_set;
      end else begin
        dlt_r <= dlt_r | dlt_set;
      end
    end
  end

  // receive fill against the programmed trigger
  assign cnt_hi = rx_count_i > rx_trig_i;
  assign cnt_lo = ({1'b0, rx_count_i} + {{CW{1'b0}}, 1'b1}) <
                  {1'b0, rx_trig_i};
  assign at_trig = rx_count_i >= rx_trig_i;
  // hysteresis between the trigger and the level below
  assign art_hi_nxt = cnt_hi ? 1'b1 : (cnt_lo ? 1'b0 : art_hi_r);

  // request-to-send pin, high at reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      art_hi_r <= 1'b0;
      rts_n_r <= 1'b1;
    end else begin
      art_hi_r <= art_hi_nxt;
      if (efc_r[`UEFC_EFC_ARTS]) begin
        rts_n_r <= art_hi_nxt;
      end else begin
        rts_n_r <= ~mdc_r[`UEFC_MDC_RTS];
      end
    end
  end

  // one-cycle event when the receive fifo reaches its trigger, only with auto rts on
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      at_trig_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      at_trig_r <= at_trig;
      evt_r <= efc_r[`UEFC_EFC_ARTS] & at_trig & ~at_trig_r;
    end
  end

  // receive matching of pause and resume characters
  assign rx_sel = uefc_pkg::uefc_sel_e'(efc_r[1:0]);
  assign tx_sel = uefc_pkg::uefc_sel_e'(efc_r[3:2]);
  uefc_seq_match u_pause (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ch_i(rx_char_i),
    .sel_i(rx_sel),
    .c1_i(pau1_r),
    .c2_i(pau2_r),
    .hit_o(pause_hit)
  );
  uefc_seq_match u_resume (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ch_i(rx_char_i),
    .sel_i(rx_sel),
    .c1_i(res1_r),
    .c2_i(res2_r),
    .hit_o(res_hit)
  );

  // paused by the peer; a pause match wins over any release
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      paused_r <= 1'b0;
    end else if (pause_hit) begin
      paused_r <= 1'b1;
    end else if (res_hit || rx_sel == uefc_pkg::UEFC_SEL_NONE) begin
      paused_r <= 1'b0;
    end else if (mdc_eff[`UEFC_MDC_ANY] && rx_char_i.valid) begin
      paused_r <= 1'b0;
    end
  end

  // transmitter halts on a pause or a high clear-to-send pin
  assign tx_hold_o = paused_r |
                     (efc_r[`UEFC_EFC_ACTS] & cts_n_s);

  // sender: pause at trigger, resume below trigger minus one
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      uefc_pkg::UEFC_FC_IDLE: begin
        if (tx_sel != uefc_pkg::UEFC_SEL_NONE &&
            (rem_paused_r ? cnt_lo : at_trig)) begin
          st_nxt = uefc_pkg::UEFC_FC_FIRST;
        end
      end
      uefc_pkg::UEFC_FC_FIRST: begin
        if (fc_ack_i) begin
          st_nxt = (tx_sel == uefc_pkg::UEFC_SEL_BOTH) ?
                   uefc_pkg::UEFC_FC_SECOND : uefc_pkg::UEFC_FC_IDLE;
        end
      end
      uefc_pkg::UEFC_FC_SECOND: begin
        if (fc_ack_i) begin
          st_nxt = uefc_pkg::UEFC_FC_IDLE;
        end
      end
    endcase
  end

  // character offered next: one of a pair, or both, the first then the second
  always_comb begin
    kind_nxt = (st_r == uefc_pkg::UEFC_FC_IDLE) ? ~rem_paused_r : kind_r;
    fc_nxt.valid = (st_nxt != uefc_pkg::UEFC_FC_IDLE);
    if (st_nxt == uefc_pkg::UEFC_FC_SECOND ||
        tx_sel == uefc_pkg::UEFC_SEL_SECOND) begin
      fc_nxt.data = kind_nxt ? pau2_r : res2_r;
    end else begin
      fc_nxt.data = kind_nxt ? pau1_r : res1_r;
    end
  end

  // sender state, kind and remote pause record
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_r <= uefc_pkg::UEFC_FC_IDLE;
      kind_r <= 1'b0;
      rem_paused_r <= 1'b0;
      fc_r <= '0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      fc_r <= fc_nxt;
      if (st_r != uefc_pkg::UEFC_FC_IDLE &&
          st_nxt == uefc_pkg::UEFC_FC_IDLE) begin
        rem_paused_r <= kind_r;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign rts_n_o = rts_n_r;
  assign dtr_n_o = ~mdc_r[`UEFC_MDC_DTR];
  assign rx_trig_evt_o = evt_r;
  assign fc_char_o = fc_r;
  assign ien_o = ien_eff;
  assign fct_o = fct_eff;
  assign mdc_o = mdc_eff;
  assign lnc_o = lnc_r;

  // checks, all on clk_i and off during reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_wr_at(logic [3:0] i);
    wr_en && idx == i;
  endsequence
  sequence s_rd_issue(logic [3:0] i);
    req && !ack_r && idx == i;
  endsequence
  sequence s_first_both;
    st_r == uefc_pkg::UEFC_FC_FIRST &&
    tx_sel == uefc_pkg::UEFC_SEL_BOTH && fc_ack_i;
  endsequence

  property p_scr_keep;
    s_wr_at(`UEFC_IDX_SCR) |=> scr_r == $past(wb_dat_i[7:0]);
  endproperty
  a_scr_keep: assert property (p_scr_keep) else $error("scratch lost");
  property p_enh_hide;
    !enh |-> ien_eff[7:4] == 4'h0 && fct_eff[5:4] == 2'h0 &&
             mdc_eff[7:5] == 3'h0;
  endproperty
  a_enh_hide: assert property (p_enh_hide) else $error("enh bits");
  property p_enh_restore;
    s_wr_at(`UEFC_IDX_EFC) ##0 wb_dat_i[4] && !enh
      |=> ien_eff[7:4] == $past(ien_r[7:4]);
  endproperty
  a_enh_restore: assert property (p_enh_restore) else $error("restore");
  property p_rst_state;
    $rose(rst_b_i) |-> efc_r == 8'h00 && ien_r == 8'h00 &&
      mdc_r == 8'h00 && lns_r == 8'h60 && rts_n_o;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset");
  property p_arts_hi;
    efc_r[6] && rx_count_i > rx_trig_i |=> rts_n_o;
  endproperty
  a_arts_hi: assert property (p_arts_hi) else $error("rts high");
  property p_arts_lo;
    efc_r[6] && {1'b0, rx_count_i} + 1 < {1'b0, rx_trig_i} |=> !rts_n_o;
  endproperty
  a_arts_lo: assert property (p_arts_lo) else $error("rts low");
  property p_rts_manual;
    !efc_r[6] |=> rts_n_o == !$past(mdc_r[1]);
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("rts pin");
  property p_cts_hold;
    efc_r[7] && pin_s[0] |-> tx_hold_o;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("cts hold");
  property p_spc_flag;
    efc_r[5] && rx_char_i.valid && rx_char_i.data == pau2_r |=> ist_spc_r;
  endproperty
  a_spc_flag: assert property (p_spc_flag) else $error("special");
  property p_pause;
    pause_hit |=> paused_r ##1 (paused_r || $past(res_hit) ||
      $past(rx_char_i.valid) || $past(rx_sel) == 2'b00);
  endproperty
  a_pause: assert property (p_pause) else $error("pause");
  property p_any;
    mdc_eff[5] && rx_char_i.valid && !pause_hit |=> !paused_r;
  endproperty
  a_any: assert property (p_any) else $error("resume any");
  property p_frdy;
    s_rd_issue(`UEFC_IDX_FRDY) |=> wb_dat_o[3:0] == ~$past(tx_full_i) &&
      wb_dat_o[7:4] == ~($past(rx_above_i) | $past(rx_tout_i));
  endproperty
  a_frdy: assert property (p_frdy) else $error("fifo ready");
  property p_fc_pair;
    s_first_both |=> fc_char_o.valid &&
      fc_char_o.data == (kind_r ? pau2_r : res2_r);
  endproperty
  a_fc_pair: assert property (p_fc_pair) else $error("pair");
endmodule

//--- sim/uefc_peer.sv
// uefc_peer: remote uart side, feeds received chars and modem pins
// assumes one clock shared with the block, takes flow chars it is sent
module uefc_peer (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire uefc_pkg::uefc_char_s fc_char_i,
  output uefc_pkg::uefc_char_s rx_char_o,
  output logic [3:0] modem_n_o,
  output logic fc_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sent[$]; // flow chars taken, in order
  int wait_n; // cycles still to stall before the next ack
  initial begin
    rx_char_o = '0;
    modem_n_o = 4'h0;
    fc_ack_o = 1'b0;
    wait_n = 0;
  end
  // one received char, valid for one cycle; data line then scrambled
  task automatic send_char(input logic [7:0] c);
    @(posedge clk_i);
    rx_char_o <= '{valid: 1'b1, data: c};
    @(posedge clk_i);
    rx_char_o <= '{valid: 1'b0, data: ~c};
  endtask
  // take flow chars, sometimes at once, sometimes after a stall
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      fc_ack_o <= 1'b0;
    end else if (fc_char_i.valid === 1'b1 && !fc_ack_o) begin
      if (wait_n == 0) begin
        fc_ack_o <= 1'b1;
        sent.push_back(fc_char_i.data);
        wait_n = $urandom_range(0, 3);
      end else begin
        wait_n = wait_n - 1;
      end
    end else begin
      fc_ack_o <= 1'b0; // ack stands one cycle only
    end
  end
endmodule

//--- sim/test_uefc_flow_ctl.sv
// test_uefc_flow_ctl: self-checking bench for the flow control block
// assumes the design files and uefc_peer are compiled before it
`include "uefc_map.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  bad_count++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module test_uefc_flow_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, cyc, stb, we, fc_ack_i;
  logic [5:0] adr;
  logic [31:0] dat_w, dat_r;
  logic wb_ack_o, rts_n_o, dtr_n_o, tx_hold_o, rx_trig_evt_o;
  logic [6:0] rx_count_i, rx_trig_i;
  logic [3:0] tx_full_i, rx_above_i, rx_tout_i, modem_n_i, sel;
  logic [7:0] lns_in; // live line status from the base logic
  int evt_n; // trigger pulses seen
  int ofs[6] = '{1, 0, -1, -2, 0, 1}; // fill around the trigger
  logic [7:0] ien_o, fct_o, mdc_o, lnc_o, rd_q, c;
  uefc_pkg::uefc_char_s rx_char_i, fc_char_o;
  int bad_count, compares, cyc_n, n;
  logic [3:0] rst_idx[8] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'he,
                             4'h9};
  logic [7:0] rst_val[8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60,
                             8'h00, 8'hf0};
  uefc_flow_ctl #(.DEPTH(64)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(wb_ack_o), .rx_char_i(rx_char_i), .rx_count_i(rx_count_i),
    .rx_trig_i(rx_trig_i), .tx_full_i(tx_full_i), .rx_above_i(rx_above_i),
    .rx_tout_i(rx_tout_i), .line_status_i(lns_in), .modem_n_i(modem_n_i),
    .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .tx_hold_o(tx_hold_o),
    .rx_trig_evt_o(rx_trig_evt_o), .fc_char_o(fc_char_o),
    .fc_ack_i(fc_ack_i), .ien_o(ien_o), .fct_o(fct_o), .mdc_o(mdc_o),
    .lnc_o(lnc_o));
  uefc_peer peer (.clk_i(clk_i), .rst_b_i(rst_b_i), .fc_char_i(fc_char_o),
    .rx_char_o(rx_char_i), .modem_n_o(modem_n_i), .fc_ack_o(fc_ack_i));
  // free running 100 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // verdict and end of run
  task automatic results;
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // count trigger pulses on the event output
  always @(posedge clk_i) begin
    if (rx_trig_evt_o === 1'b1) evt_n++;
  end
  // cut a hang short
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      results();
    end
  end
  // one classic cycle; held until ack, read data taken at that edge
  task automatic bus(input logic w, input logic [3:0] idx,
                     input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd_q = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // let registered outputs settle
  task automatic idle(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // expected fifo ready word from the fifo levels
  function automatic logic [7:0] frdy(input logic [3:0] f, a, t);
    return {~(a | t), ~f};
  endfunction
  initial begin
    {cyc, stb, we, rst_b_i} = '0;
    adr = '0;
    sel = 4'hf;
    lns_in = 8'h60;
    evt_n = 0;
    dat_w = '0;
    rx_count_i = '0;
    rx_trig_i = 7'h08;
    {tx_full_i, rx_above_i, rx_tout_i} = '0;
    bad_count = 0;
    compares = 0;
    cyc_n = 0;
    void'($urandom(61));
    idle(5);
    rst_b_i <= 1'b1;
    idle(1);
    // reset states, pins and an unmapped index
    `CHK("rts_n", 1'b1, rts_n_o)
    `CHK("dtr_n", 1'b1, dtr_n_o)
    `CHK("hold", 1'b0, tx_hold_o)
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, rst_idx[i], 8'h00);
      `CHK("reset reg", rst_val[i], rd_q)
    end
    // scratch byte keeps random values
    repeat (6) begin
      c = 8'($urandom);
      bus(1'b1, `UEFC_IDX_SCR, c);
      sel <= 4'($urandom) & 4'he;
      bus(1'b1, `UEFC_IDX_SCR, ~c);
      sel <= 4'hf;
      bus(1'b1, 4'he, ~c);
      bus(1'b0, `UEFC_IDX_SCR, 8'h00);
      `CHK("scratch", c, rd_q)
    end
    // enhanced bits gated, hidden and restored by the enable
    bus(1'b1, `UEFC_IDX_IEN, 8'hff);
    bus(1'b1, `UEFC_IDX_FCT, 8'hff);
    bus(1'b1, `UEFC_IDX_MDC, 8'he0);
    idle(1);
    `CHK("ien off", 8'h0f, ien_o)
    `CHK("fct off", 8'hcf, fct_o)
    `CHK("mdc off", 8'h00, mdc_o)
    bus(1'b1, `UEFC_IDX_EFC, 8'h10);
    bus(1'b1, `UEFC_IDX_IEN, 8'hff);
    bus(1'b1, `UEFC_IDX_MDC, 8'he0);
    bus(1'b1, `UEFC_IDX_EFC, 8'h00);
    idle(1);
    `CHK("ien latched", 8'h0f, ien_o)
    `CHK("mdc latched", 8'h00, mdc_o)
    bus(1'b1, `UEFC_IDX_EFC, 8'h10);
    idle(1);
    `CHK("ien restored", 8'hff, ien_o)
    `CHK("mdc restored", 8'he0, mdc_o)
    bus(1'b1, `UEFC_IDX_MDC, 8'h00);
    bus(1'b1, `UEFC_IDX_FCT, 8'h00);
    // rts and dtr follow the control bits
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `UEFC_IDX_MDC, 8'(i));
      idle(2);
      `CHK("rts manual", ~i[1], rts_n_o)
      `CHK("dtr", ~i[0], dtr_n_o)
    end
    // auto rts with hysteresis around a random trigger
    rx_trig_i <= 7'($urandom_range(8, 56));
    evt_n = 0;
    bus(1'b1, `UEFC_IDX_EFC, 8'h50);
    for (int i = 0; i < 6; i++) begin
      rx_count_i <= rx_trig_i + 7'(ofs[i]);
      idle(3);
      `CHK("rts auto", (i < 3 || i == 5), rts_n_o)
    end
    `CHK("trig evt", 2, evt_n)
    rx_count_i <= '0;
    // four chars: resume 11 12, pause 13 14
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'(`UEFC_IDX_RES1 + i), 8'(8'h11 + i));
    end
    // receive match per selection, pair in mode 11
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, `UEFC_IDX_EFC, 8'(m));
      if (m != 1) peer.send_char(8'h13);
      if (m != 2) peer.send_char(8'h14);
      idle(3);
      `CHK("paused", 1'b1, tx_hold_o)
      if (m != 1) peer.send_char(8'h11);
      if (m != 2) peer.send_char(8'h12);
      idle(3);
      `CHK("resumed", 1'b0, tx_hold_o)
    end
    // resume on any char
    bus(1'b1, `UEFC_IDX_EFC, 8'h12);
    bus(1'b1, `UEFC_IDX_MDC, 8'h20);
    peer.send_char(8'h13);
    peer.send_char(8'h20 + 8'($urandom_range(0, 15)));
    idle(3);
    `CHK("resume any", 1'b0, tx_hold_o)
    bus(1'b1, `UEFC_IDX_MDC, 8'h00);
    // transmit flow chars per selection, stalled by the peer
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, `UEFC_IDX_EFC, 8'h10 | 8'(m << 2));
      peer.sent.delete();
      rx_count_i <= rx_trig_i;
      idle(20);
      rx_count_i <= 7'h00;
      idle(20);
      n = (m == 3) ? 2 : 1;
      `CHK("fc count", 2 * n, peer.sent.size())
      `CHK("fc pause", (m == 1) ? 8'h14 : 8'h13, peer.sent[0])
      `CHK("fc resume", (m == 1) ? 8'h12 : 8'h11, peer.sent[n])
    end
    // special detect, flow control bits cleared first
    bus(1'b1, `UEFC_IDX_EFC, 8'h30);
    peer.send_char(8'h14);
    idle(2);
    bus(1'b0, `UEFC_IDX_IST, 8'h00);
    `CHK("special", 8'h11, rd_q)
    bus(1'b0, `UEFC_IDX_IST, 8'h00);
    `CHK("special clr", 8'h01, rd_q)
    // auto cts halts while the pin is high
    bus(1'b1, `UEFC_IDX_EFC, 8'h80);
    peer.modem_n_o[0] <= 1'b1;
    idle(5);
    `CHK("cts stop", 1'b1, tx_hold_o)
    peer.modem_n_o[0] <= 1'b0;
    idle(5);
    `CHK("cts go", 1'b0, tx_hold_o)
    // only the cts pin changed since reset; a read clears the deltas
    bus(1'b0, `UEFC_IDX_MDS, 8'h00);
    `CHK("modem delta", 8'hf1, rd_q)
    bus(1'b0, `UEFC_IDX_MDS, 8'h00);
    `CHK("modem clr", 8'hf0, rd_q)
    // fifo ready word with random levels
    repeat (8) begin
      tx_full_i <= 4'($urandom);
      rx_above_i <= 4'($urandom);
      rx_tout_i <= 4'($urandom);
      lns_in <= 8'($urandom);
      idle(2);
      bus(1'b0, `UEFC_IDX_FRDY, 8'h00);
      c = frdy(tx_full_i, rx_above_i, rx_tout_i);
      `CHK("fifo rdy", c, rd_q)
      bus(1'b0, `UEFC_IDX_LNS, 8'h00);
      `CHK("line status", lns_in, rd_q)
    end
    results();
  end
endmodule
